// ==== dast_pkg.sv ====
package dast_pkg;

  // ----------------------------------------------------------------
  // clock and bus timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;
  localparam int unsigned SCL_MAX_KHZ     = 400;
  // longest stretch, rounded down
  localparam int unsigned STRETCH_MS      = 1;
  localparam int unsigned STRETCH_CYC_DEF = STRETCH_MS * CYC_PER_MS;
  // least low time before abandoning, rounded up
  localparam int unsigned TIMEOUT_MS      = 25;
  localparam int unsigned TIMEOUT_CYC_DEF = TIMEOUT_MS * CYC_PER_MS;

  // ----------------------------------------------------------------
  // addressing and framing
  // ----------------------------------------------------------------
  localparam logic [7:0] MC_BASE   = 8'hB0;
  localparam logic [7:0] EE_BASE   = 8'hA0;
  localparam logic [7:0] MAX_BLOCK = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE  = 8'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ZERO_BITS = 4'h0;
  localparam logic [3:0] ONE_BIT   = 4'h1;
  localparam int unsigned EE_DEPTH = 256;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_CMD,
    KIND_DATA,
    KIND_STOP,
    KIND_READ
  } dast_kind_type;

  typedef struct packed {
    dast_kind_type kind;
    logic [7:0]    data;
  } dast_rx_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_IGN
  } dast_state_type;

  // address byte matches base plus twice the strap value
  function automatic logic addr_hit(input logic [7:0] rx_byte,
                                    input logic [7:0] base,
                                    input logic [2:0] strap);
    logic [7:0] addr;
    addr = base + {4'h0, strap, 1'h0};
    return rx_byte[7:1] == addr[7:1];
  endfunction

endpackage

// ==== dast_skid.sv ====
`timescale 1ns/1ps
module dast_skid (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  dast_pkg::dast_rx_type     in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output dast_pkg::dast_rx_type     out_data
);
  import dast_pkg::*;

  logic        out_valid_q;
  logic        skid_valid_q;
  dast_rx_type out_data_q;
  dast_rx_type skid_data_q;
  logic        push;
  logic        pop;
  logic        head_free;

  assign in_ready  = ~skid_valid_q;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;
  assign push      = in_valid & ~skid_valid_q;
  assign pop       = out_valid_q & out_ready;
  assign head_free = ~out_valid_q | pop;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_valid_q  <= 1'h0;
      skid_valid_q <= 1'h0;
      out_data_q   <= '0;
      skid_data_q  <= '0;
    end else if (head_free && skid_valid_q) begin
      out_data_q   <= skid_data_q;
      out_valid_q  <= 1'h1;
      skid_valid_q <= 1'h0;
    end else if (head_free) begin
      out_valid_q  <= push;
      if (push) begin
        out_data_q <= in_data;
      end
    end else if (push) begin
      skid_data_q  <= in_data;
      skid_valid_q <= 1'h1;
    end
  end

endmodule

// ==== dast_target.sv ====
`timescale 1ns/1ps
module dast_target #(
  parameter int unsigned STRETCH_CYC = dast_pkg::STRETCH_CYC_DEF,
  parameter int unsigned TIMEOUT_CYC = dast_pkg::TIMEOUT_CYC_DEF
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  input  wire logic             addr_strap_bit0,
  input  wire logic             addr_strap_bit1,
  input  wire logic             addr_strap_bit2,
  output dast_pkg::dast_rx_type mc_rx,
  output logic                  mc_rx_valid,
  input  wire logic             mc_rx_ready,
  input  wire logic             mc_tx_valid,
  input  wire logic [7:0]       mc_tx_data,
  output logic                  mc_tx_ready,
  output logic                  bus_timeout,
  output logic                  bus_busy
);
  import dast_pkg::*;

  localparam int unsigned SW = $clog2(STRETCH_CYC + 1);
  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]     scl_sync_q;
  logic [1:0]     sda_sync_q;
  logic [2:0]     strap_meta_q;
  logic [2:0]     strap_q;
  logic           scl_prev_q;
  logic           sda_prev_q;
  dast_state_type st_q;
  logic [3:0]     cnt_q;
  logic [7:0]     sh_q;
  logic [7:0]     tx_q;
  logic [7:0]     nbytes_q;
  logic [7:0]     ee_ptr_q;
  logic [7:0]     ee_dat_q;
  logic           sel_mc_q;
  logic           sel_ee_q;
  logic           addr_ph_q;
  logic           rd_q;
  logic           ee_pend_q;
  logic           stop_pend_q;
  logic           sda_oe_q;
  logic           scl_oe_q;
  logic           mc_tx_ready_q;
  logic           timeout_q;
  logic           busy_q;
  logic           pin_low_q;
  logic [SW-1:0]  str_cnt_q;
  logic [TW-1:0]  to_cnt_q;
  logic [7:0]     ee_mem [EE_DEPTH];

  // ----------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic bus_abort;
  logic fall_act;
  logic str_exp;

  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign bus_abort = ~scl_s & (to_cnt_q == TW'(TIMEOUT_CYC - 1));
  // a stalled fall action is retried every cycle while SCL is held
  assign fall_act  = scl_fall | scl_oe_q;
  assign str_exp   = str_cnt_q >= SW'(STRETCH_CYC - 2);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic        hit_mc;
  logic        hit_ee;
  logic        blk_full;
  logic        rx_done;
  logic        rx_ee;
  logic        rx_mc;
  logic        rd_req;
  logic        push_byte;
  logic        rx_ok;
  logic        rx_hold;
  logic        load_need;
  logic        mc_src;
  logic        mc_take;
  logic        load_hold;
  logic        hold;
  logic        ee_wr;
  logic [7:0]  load_val;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [7:0]  fifo_in_byte;
  dast_kind_type fifo_in_kind;
  dast_rx_type fifo_in_data;

  assign hit_mc = addr_hit(sh_q, MC_BASE, strap_q);
  // EEPROM address from the same straps
  assign hit_ee = addr_hit(sh_q, EE_BASE, strap_q);

  assign blk_full  = nbytes_q == MAX_BLOCK;
  assign rx_done   = fall_act & (st_q == ST_RX) & (cnt_q == BYTE_BITS);
  assign rx_ee     = rx_done & ~addr_ph_q & sel_ee_q;
  assign rx_mc     = rx_done & ~addr_ph_q & sel_mc_q & ~blk_full;
  assign rd_req    = rx_done & addr_ph_q & hit_mc & sh_q[0];
  assign push_byte = (rx_mc | rd_req) & ~stop_pend_q;
  assign rx_ok     = push_byte & fifo_in_ready;
  // stretch for buffer space ends at the limit
  assign rx_hold   = (rx_mc | rd_req) & ~rx_ok & ~str_exp;

  assign load_need = fall_act & (((st_q == ST_ACK) & rd_q & sda_oe_q) | (st_q == ST_MACK));
  // past the block limit a controller read sends only idle bytes
  assign mc_src    = load_need & sel_mc_q & ~blk_full;
  assign mc_take   = mc_src & mc_tx_valid & ~bus_abort;
  // stretch for read data ends at the limit
  assign load_hold = mc_src & ~mc_tx_valid & ~str_exp;
  assign hold      = (rx_hold | load_hold) & ~bus_abort;

  // an EEPROM read returns the byte at the pointer; a controller read returns mc_tx_data or the idle byte
  assign load_val  = sel_ee_q ? ee_mem[ee_ptr_q] : (mc_take ? mc_tx_data : IDLE_BYTE);
  // pending byte is stored at STOP or when a page byte follows
  assign ee_wr     = ee_pend_q & ~bus_abort & (bus_stop | (rx_ee & (nbytes_q != ZERO_BYTE)));

  // first byte after the address is tagged as command
  assign fifo_in_kind  = stop_pend_q ? KIND_STOP :
                         addr_ph_q ? KIND_READ :
                         (nbytes_q == ZERO_BYTE) ? KIND_CMD : KIND_DATA;
  assign fifo_in_byte  = stop_pend_q ? ZERO_BYTE : sh_q;
  assign fifo_in_data  = '{kind: fifo_in_kind, data: fifo_in_byte};
  assign fifo_in_valid = stop_pend_q | push_byte;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign scl_o       = pin_low_q;
  assign sda_o       = pin_low_q;
  assign scl_oe      = scl_oe_q;
  assign sda_oe      = sda_oe_q;
  assign mc_tx_ready = mc_tx_ready_q;
  assign bus_timeout = timeout_q;
  assign bus_busy    = busy_q;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // oversampled pins, far above 400 kbps
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'h1;
      sda_prev_q <= 1'h1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // open pins read high through the pad pull-up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_meta_q <= 3'h7;
      strap_q      <= 3'h7;
    end else begin
      strap_meta_q <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
      strap_q      <= strap_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // stretch length counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      str_cnt_q <= '0;
    end else begin
      str_cnt_q <= scl_oe_q ? str_cnt_q + SW'(1) : '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      to_cnt_q <= '0;
    end else if (scl_s) begin
      to_cnt_q <= '0;
    end else if (to_cnt_q != TW'(TIMEOUT_CYC)) begin
      to_cnt_q <= to_cnt_q + TW'(1);
    end
  end

  // ----------------------------------------------------------------
  // handshakes and flags
  // ----------------------------------------------------------------
  // STOP closes a controller write of any length
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_pend_q   <= 1'h0;
      mc_tx_ready_q <= 1'h0;
      timeout_q     <= 1'h0;
      busy_q        <= 1'h0;
      pin_low_q     <= 1'h0;
      scl_oe_q      <= 1'h0;
    end else begin
      stop_pend_q   <= (stop_pend_q & ~fifo_in_ready) | (bus_stop & sel_mc_q & ~rd_q);
      mc_tx_ready_q <= mc_take;
      timeout_q     <= bus_abort;
      busy_q        <= (busy_q | bus_start) & ~bus_stop & ~bus_abort;
      scl_oe_q      <= hold;
    end
  end

  // ----------------------------------------------------------------
  // user storage
  // ----------------------------------------------------------------
  // only bus writes reach the array
  always_ff @(posedge clk_sys) begin
    if (ee_wr) begin
      ee_mem[ee_ptr_q] <= ee_dat_q;
    end
  end

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q      <= ST_IDLE;
      cnt_q     <= ZERO_BITS;
      sh_q      <= ZERO_BYTE;
      tx_q      <= ZERO_BYTE;
      nbytes_q  <= ZERO_BYTE;
      ee_ptr_q  <= ZERO_BYTE;
      ee_dat_q  <= ZERO_BYTE;
      sel_mc_q  <= 1'h0;
      sel_ee_q  <= 1'h0;
      addr_ph_q <= 1'h0;
      rd_q      <= 1'h0;
      ee_pend_q <= 1'h0;
      sda_oe_q  <= 1'h0;
    end else if (bus_abort) begin
      // drop the transfer and free SDA
      st_q      <= ST_IDLE;
      sda_oe_q  <= 1'h0;
      ee_pend_q <= 1'h0;
      sel_mc_q  <= 1'h0;
      sel_ee_q  <= 1'h0;
    end else if (bus_start) begin
      st_q      <= ST_RX;
      addr_ph_q <= 1'h1;
      cnt_q     <= ZERO_BITS;
      sda_oe_q  <= 1'h0;
      ee_pend_q <= 1'h0;
    end else if (bus_stop) begin
      st_q      <= ST_IDLE;
      sda_oe_q  <= 1'h0;
      ee_pend_q <= 1'h0;
      sel_mc_q  <= 1'h0;
      sel_ee_q  <= 1'h0;
    end else if (scl_rise) begin
      if (st_q == ST_RX && cnt_q != BYTE_BITS) begin
        sh_q  <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + ONE_BIT;
      end else if (st_q == ST_TX) begin
        cnt_q <= cnt_q + ONE_BIT;
      end else if (st_q == ST_MACK && sda_s) begin
        st_q <= ST_IGN;
      end
    end else if (fall_act && !hold) begin
      // SDA only changes here, with SCL low
      unique case (st_q)
        ST_RX: begin
          if (cnt_q == BYTE_BITS && addr_ph_q) begin
            // each target answers only its own address
            addr_ph_q <= 1'h0;
            nbytes_q  <= ZERO_BYTE;
            rd_q      <= sh_q[0];
            sel_mc_q  <= hit_mc;
            sel_ee_q  <= hit_ee;
            // no match leaves the address unacknowledged
            st_q      <= (hit_mc | hit_ee) ? ST_ACK : ST_IGN;
            sda_oe_q  <= hit_ee | (hit_mc & (~sh_q[0] | rx_ok));
          end else if (cnt_q == BYTE_BITS) begin
            st_q     <= ST_ACK;
            // controller bytes past the block limit are refused; EEPROM bytes are always acknowledged
            sda_oe_q <= sel_ee_q | rx_ok;
            if (!blk_full) begin
              nbytes_q <= nbytes_q + ONE_BYTE;
            end
            if (sel_ee_q && nbytes_q == ZERO_BYTE) begin
              ee_ptr_q <= sh_q;
            end else if (sel_ee_q) begin
              ee_dat_q  <= sh_q;
              ee_pend_q <= 1'h1;
              if (ee_pend_q) begin
                ee_ptr_q <= ee_ptr_q + ONE_BYTE;
              end
            end
          end
        end
        ST_ACK: begin
          cnt_q    <= ZERO_BITS;
          sda_oe_q <= 1'h0;
          if (!sda_oe_q) begin
            st_q <= ST_IGN;
          end else if (rd_q) begin
            st_q     <= ST_TX;
            tx_q     <= load_val;
            sda_oe_q <= ~load_val[7];
            if (sel_ee_q) begin
              ee_ptr_q <= ee_ptr_q + ONE_BYTE;
            end
            if (!blk_full) begin
              nbytes_q <= nbytes_q + ONE_BYTE;
            end
          end else begin
            st_q <= ST_RX;
          end
        end
        ST_TX: begin
          if (cnt_q == BYTE_BITS) begin
            st_q     <= ST_MACK;
            sda_oe_q <= 1'h0;
          end else begin
            tx_q     <= {tx_q[6:0], 1'h0};
            sda_oe_q <= ~tx_q[6];
          end
        end
        ST_MACK: begin
          // next byte of a word or block read
          st_q     <= ST_TX;
          cnt_q    <= ZERO_BITS;
          tx_q     <= load_val;
          sda_oe_q <= ~load_val[7];
          if (sel_ee_q) begin
            ee_ptr_q <= ee_ptr_q + ONE_BYTE;
          end
          if (!blk_full) begin
            nbytes_q <= nbytes_q + ONE_BYTE;
          end
        end
        ST_IDLE, ST_IGN: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // controller receive buffer
  // ----------------------------------------------------------------
  dast_skid u_rx_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (mc_rx_valid),
    .out_ready (mc_rx_ready),
    .out_data  (mc_rx)
  );

endmodule

// ==== dast_target_checker.sv ====
`timescale 1ns/1ps
module dast_target_checker #(
  parameter int unsigned STRETCH_CYC = 64,
  parameter int unsigned TIMEOUT_CYC = 2000
) (
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic            scl_i,
  input wire logic            scl_oe,
  input wire logic            sda_oe,
  input dast_pkg::dast_rx_type mc_rx,
  input wire logic            mc_rx_valid,
  input wire logic            mc_rx_ready,
  input wire logic            mc_tx_valid,
  input wire logic            mc_tx_ready,
  input wire logic            bus_timeout,
  input wire logic            bus_busy
);
  import dast_pkg::*;
  int unsigned str_cnt_q;
  int unsigned low_cnt_q;
  logic        to_seen_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ------
  // helper counters
  // ------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      str_cnt_q <= 0;
    else
      str_cnt_q <= scl_oe ? str_cnt_q + 1 : 0;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      low_cnt_q <= 0;
    else if (scl_i)
      low_cnt_q <= 0;
    else if (low_cnt_q < TIMEOUT_CYC + 16)
      low_cnt_q <= low_cnt_q + 1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      to_seen_q <= 1'b0;
    else if (scl_i)
      to_seen_q <= 1'b0;
    else if (bus_timeout)
      to_seen_q <= 1'b1;
  end

  chk_stretch_limit: assert property (str_cnt_q <= STRETCH_CYC + 4)
    else $error("clock stretch held too long");
  chk_timeout_early: assert property ($rose(bus_timeout) |-> low_cnt_q >= TIMEOUT_CYC)
    else $error("timeout before the low limit");
  chk_timeout_late: assert property (low_cnt_q > TIMEOUT_CYC + 12 |-> to_seen_q)
    else $error("no timeout after long low clock");
  chk_lines_freed: assert property (bus_timeout |=> !sda_oe && !scl_oe && !bus_busy)
    else $error("lines still held after timeout");
  chk_no_start: assert property ($rose(sda_oe) |-> !$past(scl_i))
    else $error("data pulled low while clock high");
  chk_rx_stands: assert property (mc_rx_valid && !mc_rx_ready |=> mc_rx_valid && $stable(mc_rx))
    else $error("event changed before accepted");
  chk_tx_pulse: assert property (mc_tx_ready |=> !mc_tx_ready)
    else $error("read byte taken twice");
  chk_tx_cause: assert property (mc_tx_ready |-> $past(mc_tx_valid))
    else $error("read byte taken without valid");
  chk_idle_quiet: assert property (!bus_busy [*2] |-> !sda_oe)
    else $error("data driven while bus idle");
endmodule

bind dast_target dast_target_checker #(.STRETCH_CYC(STRETCH_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk_sys, .rst, .scl_i, .scl_oe, .sda_oe, .mc_rx, .mc_rx_valid, .mc_rx_ready,
  .mc_tx_valid, .mc_tx_ready, .bus_timeout, .bus_busy);

// ==== dast_host_model.sv ====
`timescale 1ns/1ps
module dast_host_model #(
  parameter int LOW_CYC  = 264,
  parameter int HIGH_CYC = 240,
  parameter int GAP_CYC  = 400
) (
  input  wire logic clk_sys,
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_low,
  output logic      sda_low,
  output logic      stuck
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // ------
  // bus conditions
  // ------
  task automatic cond(input logic first, input logic second);
    sda_low <= first;
    hold(LOW_CYC);
    scl_low <= 1'b0;
    hold(HIGH_CYC);
    sda_low <= second;
  endtask
  task automatic start();
    cond(1'b0, 1'b1);
    hold(HIGH_CYC);
    scl_low <= 1'b1;
    hold(4);
  endtask
  task automatic stop();
    cond(1'b1, 1'b0);
    hold(GAP_CYC);
  endtask
  task automatic bitx(input logic b, output logic r);
    int n;
    n = 0;
    sda_low <= !b;
    hold(LOW_CYC);
    scl_low <= 1'b0;
    @(posedge clk_sys);
    while (!scl_w && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000)
      stuck <= 1'b1;
    hold(HIGH_CYC / 2);
    r = sda_w;
    hold(HIGH_CYC / 2);
    scl_low <= 1'b1;
    hold(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import dast_pkg::*;
  logic        clk_sys, rst, scl_low, sda_low, stuck, rx_hold, tx_idx;
  logic        scl_o, scl_oe, sda_o, sda_oe, mc_rx_valid, mc_rx_ready;
  logic        mc_tx_valid, mc_tx_ready, bus_timeout, bus_busy;
  logic [2:0]  strap;
  logic [7:0]  mc_tx_data;
  logic [7:0]  tx_tab [2];
  dast_rx_type mc_rx;
  dast_rx_type rxq [$];
  int          error_cnt = 0;
  int          tests_run = 0;
  // open-drain lines with pull-ups
  // an enabled device pulls the line low when its drive value is 0
  wire         scl_w = !(scl_low || (scl_oe && !scl_o));
  wire         sda_w = !(sda_low || (sda_oe && !sda_o));

  dast_target #(.STRETCH_CYC(64), .TIMEOUT_CYC(2000)) dut (
    .clk_sys, .rst, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe,
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .mc_rx, .mc_rx_valid, .mc_rx_ready, .mc_tx_valid, .mc_tx_data, .mc_tx_ready,
    .bus_timeout, .bus_busy);
  dast_host_model host (.clk_sys, .scl_w, .sda_w, .scl_low, .sda_low, .stuck);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys) begin
    mc_rx_ready <= !rx_hold;
    if (mc_rx_valid && mc_rx_ready)
      rxq.push_back(mc_rx);
    if (mc_tx_ready) begin
      tx_idx <= !tx_idx;
      mc_tx_data <= tx_tab[!tx_idx];
    end
  end

  // ------
  // shared tasks
  // ------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clk_sys);
    #1;
    n++;
    if (n > 9000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_eeprom();
    logic       a;
    logic [7:0] d;
    host.start();
    check(bus_busy, 1);
    host.wbyte(EE_BASE, a);
    check(a, 1);
    host.wbyte(8'h47, a);
    check(a, 1);
    host.wbyte(8'h3C, a);
    check(a, 1);
    host.stop();
    host.start();
    host.wbyte(EE_BASE, a);
    host.wbyte(8'h47, a);
    host.start();
    host.wbyte(EE_BASE | 8'h01, a);
    check(a, 1);
    host.rbyte(1'b1, d);
    check(d, 8'h3C);
    host.stop();
    check(rxq.size(), 0);
    $display("test eeprom done");
  endtask
  task automatic t_mc_write();
    logic a;
    int   n;
    rx_hold <= 1'b1;
    host.start();
    host.wbyte(MC_BASE, a);
    check(a, 1);
    host.wbyte(8'h8D, a);
    host.wbyte(8'h12, a);
    fork
      host.wbyte(8'h34, a);
      begin
        n = 0;
        while (scl_oe !== 1'b1)
          tick(n);
        repeat (16) @(posedge clk_sys);
        rx_hold <= 1'b0;
      end
    join
    check(a, 1);
    host.stop();
    check(rxq.size(), 4);
    check(rxq[0], {KIND_CMD, 8'h8D});
    check(rxq[1], {KIND_DATA, 8'h12});
    check(rxq[2], {KIND_DATA, 8'h34});
    check(rxq[3].kind, KIND_STOP);
    $display("test mc_write done");
  endtask
  task automatic t_mc_read();
    logic       a;
    logic [7:0] d;
    rxq.delete();
    mc_tx_valid <= 1'b1;
    host.start();
    host.wbyte(MC_BASE, a);
    host.wbyte(8'h8B, a);
    host.start();
    host.wbyte(MC_BASE | 8'h01, a);
    check(a, 1);
    host.rbyte(1'b0, d);
    check(d, 8'h5A);
    host.rbyte(1'b1, d);
    check(d, 8'hC3);
    host.stop();
    mc_tx_valid <= 1'b0;
    check(rxq[0], {KIND_CMD, 8'h8B});
    check(rxq[1].kind, KIND_READ);
    $display("test mc_read done");
  endtask
  task automatic t_timeout();
    logic r;
    int   n;
    host.start();
    host.bitx(1'b1, r);
    host.bitx(1'b0, r);
    n = 0;
    while (bus_timeout !== 1'b1)
      tick(n);
    @(posedge clk_sys);
    #1;
    check({sda_oe, scl_oe, bus_busy}, 0);
    @(posedge clk_sys);
    host.stop();
    $display("test timeout done");
  endtask
  task automatic t_strap();
    logic a;
    logic r;
    // middle pin grounded, the other two left open
    strap <= 3'b101;
    repeat (4) @(posedge clk_sys);
    host.start();
    host.bitx(1'b1, r);
    host.bitx(1'b0, r);
    host.start();
    host.wbyte(EE_BASE + 8'h0A, a);
    check(a, 1);
    host.stop();
    host.start();
    host.wbyte(MC_BASE + 8'h0A, a);
    check(a, 1);
    host.stop();
    host.start();
    host.wbyte(EE_BASE, a);
    check(a, 0);
    host.stop();
    $display("test strap done");
  endtask

  initial begin
    rst = 1'b1;
    strap = 3'b000;
    rx_hold = 1'b0;
    mc_rx_ready = 1'b0;
    mc_tx_valid = 1'b0;
    tx_idx = 1'b0;
    tx_tab[0] = 8'h5A;
    tx_tab[1] = 8'hC3;
    mc_tx_data = 8'h5A;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_eeprom();
    t_mc_write();
    t_mc_read();
    t_timeout();
    t_strap();
    check(stuck, 0);
    report_and_stop();
  end
  initial begin
    repeat (110000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
endmodule
